/* hw/sysclk_defs.svh */
`ifndef SYSCLK_DEFS_SVH
`define SYSCLK_DEFS_SVH

`define CTRL_ADDR 16'h00BE
`define TRIM_ADDR 16'h4002

`define CTRL_RESET 8'h21
`define TRIM_RESET 8'hFF
`define DIV_RESET 3'h1
`define DIV_SCAN 3'h1

`define BIT_SHUTDOWN 7
`define BIT_RSVD 6
`define BIT_FIRST_PWR 5
`define BIT_TICK_CLR 4
`define BIT_HOLD 3
`define DIV_MSB 2

`define GPIO_W 9

// Nominal table base and true rate (24/25 of nominal)
`define OSC_NOMINAL_KHZ 25000
`define OSC_ACTUAL_KHZ ((`OSC_NOMINAL_KHZ * 24) / 25)
`define TICK_PERIOD_NS 5120

`endif

/* hw/sysclk_pkg.sv */
package sysclk_pkg;
  typedef logic [15:0] addr_t;
  typedef logic [7:0] byte_t;
  typedef logic [2:0] div_sel_t;
  typedef logic [8:0] gpio_t;
  typedef enum logic [1:0] {
    PWR_RUN = 2'b01,
    PWR_OFF = 2'b10
  } power_state_t;
endpackage

/* hw/system_clock_and_power_control.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sysclk_defs.svh"

module system_clock_and_power_control (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire sysclk_pkg::addr_t sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire sysclk_pkg::byte_t sfr_wdata_i,
  output sysclk_pkg::byte_t sfr_rdata_o,
  input wire logic scan_mode_i,
  input wire sysclk_pkg::gpio_t gpio_i,
  input wire logic battery_insert_i,
  output logic sys_clk_o,
  output logic sys_tick_o,
  output sysclk_pkg::div_sel_t div_sel_o,
  output logic shutdown_o,
  output logic wake_por_o,
  output logic rtc_tick_clr_o,
  output logic port_hold_o,
  output sysclk_pkg::byte_t osc_trim_code_o
);
  import sysclk_pkg::*;

  // Bus decode
  wire ctrl_sel = (sfr_addr_i == `CTRL_ADDR);
  wire trim_sel = (sfr_addr_i == `TRIM_ADDR);
  wire ctrl_wr = sfr_wr_i && ctrl_sel;
  wire trim_wr = sfr_wr_i && trim_sel;

  // Pin synchronisers, three stages each
  logic scan_s1_q, scan_s2_q, scan_s3_q, scan_q;
  gpio_t gpio_s1_q, gpio_s2_q, gpio_s3_q, gpio_q;

  always_ff @(posedge ref_clk_i) begin
    scan_s1_q <= scan_mode_i;
    scan_s2_q <= scan_s1_q;
    scan_s3_q <= scan_s2_q;
    gpio_s1_q <= gpio_i;
    gpio_s2_q <= gpio_s1_q;
    gpio_s3_q <= gpio_s2_q;
  end

  wire scan_agree = (scan_s2_q == scan_s3_q);
  wire scan_d = scan_agree ? scan_s3_q : scan_q;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      scan_q <= 1'b0;
    end else begin
      scan_q <= scan_d;
    end
  end

  // Per-pin debounce and falling-edge detect
  gpio_t gpio_d;
  gpio_t gpio_fall;

  genvar g;
  generate
    for (g = 0; g < `GPIO_W; g++) begin : g_pin
      assign gpio_d[g] = (gpio_s2_q[g] == gpio_s3_q[g]) ? gpio_s3_q[g] : gpio_q[g];
      assign gpio_fall[g] = gpio_q[g] && !gpio_d[g];
    end
  endgenerate

  wire any_fall = |gpio_fall;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      gpio_q <= '1;
    end else begin
      gpio_q <= gpio_d;
    end
  end

  // Control and trim registers
  div_sel_t div_q;
  logic hold_q;
  byte_t trim_q;
  logic tick_clr_q;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      div_q <= `DIV_RESET;
      hold_q <= 1'b0;
      trim_q <= `TRIM_RESET;
    end else begin
      if (ctrl_wr) begin
        div_q <= sfr_wdata_i[`DIV_MSB:0];
        hold_q <= sfr_wdata_i[`BIT_HOLD];
      end
      if (trim_wr) begin
        trim_q <= sfr_wdata_i;
      end
    end
  end

  // Tick clear held in a flop, one-cycle pulse; zero writes ignored
  wire tick_clr_d = ctrl_wr && sfr_wdata_i[`BIT_TICK_CLR];

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tick_clr_q <= 1'b0;
    end else begin
      tick_clr_q <= tick_clr_d;
    end
  end

  assign rtc_tick_clr_o = tick_clr_q;
  assign port_hold_o = hold_q;
  assign osc_trim_code_o = trim_q;

  // First-power-up flag, captured once after reset release
  logic first_pwr_q, armed_q;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      first_pwr_q <= 1'b1;
      armed_q <= 1'b1;
    end else if (armed_q) begin
      first_pwr_q <= battery_insert_i;
      armed_q <= 1'b0;
    end
  end

  // Power state machine
  power_state_t state_q, state_d;
  wire off_req = ctrl_wr && sfr_wdata_i[`BIT_SHUTDOWN] && !scan_q;
  wire off_clr = ctrl_wr && !sfr_wdata_i[`BIT_SHUTDOWN];

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PWR_RUN: begin
        if (off_req) begin
          state_d = PWR_OFF;
        end
      end
      PWR_OFF: begin
        if (any_fall || off_clr) begin
          state_d = PWR_RUN;
        end
      end
      default: begin
        state_d = PWR_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_q <= PWR_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  logic wake_q;
  wire wake_d = (state_q == PWR_OFF) && any_fall;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= wake_d;
    end
  end

  assign shutdown_o = (state_q == PWR_OFF);
  assign wake_por_o = wake_q;

  // Glitch-free power-of-two divider of the oscillator clock
  div_sel_t eff_div;
  assign eff_div = scan_q ? `DIV_SCAN : div_q;
  assign div_sel_o = eff_div;

  div_sel_t active_q;
  logic [6:0] cnt_q;
  logic clk_q;
  logic tick_q;

  wire [7:0] full = 8'h01 << active_q;
  wire [6:0] mask = 7'(full - 8'h01);
  wire period_end = ((cnt_q & mask) == mask);

  // New ratio only takes effect at a period boundary
  div_sel_t next_div;
  assign next_div = period_end ? eff_div : active_q;
  wire [6:0] cnt_d = period_end ? 7'h00 : 7'(cnt_q + 7'h01);
  wire [7:0] full_n = 8'h01 << next_div;
  wire [6:0] half_n = 7'(full_n >> 1);
  wire clk_d = (next_div == 3'h0) ? 1'b1 : (cnt_d < half_n);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      active_q <= `DIV_RESET;
      cnt_q <= 7'h00;
      clk_q <= 1'b1;
      tick_q <= 1'b0;
    end else begin
      active_q <= next_div;
      cnt_q <= cnt_d;
      clk_q <= clk_d;
      tick_q <= period_end;
    end
  end

  assign sys_clk_o = clk_q;
  assign sys_tick_o = tick_q;

  // Register read, one cycle latency
  wire [7:0] ctrl_rd = {shutdown_o, 1'b0, first_pwr_q, 1'b0, hold_q, div_q};
  wire [7:0] rd_mux = ctrl_sel ? ctrl_rd : (trim_sel ? trim_q : 8'h00);
  byte_t rdata_q;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
    end else if (sfr_rd_i) begin
      rdata_q <= rd_mux;
    end
  end

  assign sfr_rdata_o = rdata_q;

  // Checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_off_fall;
    (state_q == PWR_OFF) && any_fall;
  endsequence

  sequence s_wake_done;
    wake_por_o && !shutdown_o;
  endsequence

  sequence s_clr_pulse;
    rtc_tick_clr_o ##1 !rtc_tick_clr_o;
  endsequence

  a_div_scan_force: assert property (
    scan_q |-> div_sel_o == 3'h1)
    else $error("divide select not forced in scan");

  a_scan_no_off: assert property (
    scan_q && !shutdown_o |=> !shutdown_o)
    else $error("shutdown entered during scan");

  a_off_entry: assert property (
    ctrl_wr && sfr_wdata_i[7] && !scan_q && !shutdown_o |=> shutdown_o)
    else $error("shutdown write ignored");

  a_wake_por: assert property (
    s_off_fall |=> s_wake_done)
    else $error("pin fall did not wake");

  a_tick_clear: assert property (
    (ctrl_wr && sfr_wdata_i[4]) ##1 !(ctrl_wr && sfr_wdata_i[4]) |-> s_clr_pulse)
    else $error("tick clear pulse wrong");

  a_clr_zero_idle: assert property (
    !(ctrl_wr && sfr_wdata_i[4]) |=> !rtc_tick_clr_o)
    else $error("tick clear without write of one");

  a_ctrl_read_zeros: assert property (
    sfr_rd_i && ctrl_sel |=> sfr_rdata_o[6] == 1'b0 && sfr_rdata_o[4] == 1'b0)
    else $error("reserved or write-only bit read nonzero");

  a_trim_store: assert property (
    trim_wr |=> osc_trim_code_o == $past(sfr_wdata_i))
    else $error("trim write lost");

  a_hold_store: assert property (
    ctrl_wr |=> port_hold_o == $past(sfr_wdata_i[3]))
    else $error("hold bit not driven");

  a_flag_fixed: assert property (
    !armed_q |=> $stable(first_pwr_q))
    else $error("first power flag changed");

  a_ratio_two: assert property (
    sys_tick_o && active_q == 3'h1 && eff_div == 3'h1 |=> !sys_tick_o ##1 sys_tick_o)
    else $error("divide by two period wrong");

  a_switch_edge: assert property (
    !period_end |=> active_q == $past(active_q))
    else $error("ratio changed mid period");

  a_ratio_one: assert property (
    active_q == 3'h0 && eff_div == 3'h0 |=> sys_tick_o && sys_clk_o)
    else $error("divide by one output wrong");

  a_wake_only_off: assert property (
    !shutdown_o |=> !wake_por_o)
    else $error("wake pulse while running");

  a_off_leave: assert property (
    shutdown_o && ctrl_wr && !sfr_wdata_i[7] |=> !shutdown_o)
    else $error("shutdown not left on write of zero");

endmodule // system_clock_and_power_control
`default_nettype wire

/* tb/sfr_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sfr_core_model (
  input wire logic clk_i,
  input wire sysclk_pkg::byte_t rdata_i,
  output sysclk_pkg::addr_t addr_o,
  output logic wr_o,
  output logic rd_o,
  output sysclk_pkg::byte_t wdata_o
);
  import sysclk_pkg::*;
  initial begin
    addr_o = 16'h0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end
  // Strobe held falling edge to falling edge, so one rising edge takes it
  task automatic wr_reg(input addr_t a, input byte_t d);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    wdata_o = ~d;
  endtask
  task automatic rd_reg(input addr_t a, output byte_t d);
    @(negedge clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    @(negedge clk_i);
    d = rdata_i;
  endtask
endmodule // sfr_core_model
`default_nettype wire

/* tb/system_clock_and_power_control_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module system_clock_and_power_control_tb_top;
  import sysclk_pkg::*;
  typedef struct {addr_t a; byte_t d; byte_t r;} row_t;
  logic ref_clk_i, rst_i, scan_mode_i, battery_insert_i, wr, rd, sclk, tick, shut, wake, clr, hold;
  gpio_t gpio_i;
  addr_t addr;
  byte_t wdata, rdata, trim;
  div_sel_t div;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  int clr_cnt = 0;
  int wake_cnt = 0;
  int n;
  int hi;
  row_t rows [5] = '{'{16'h4002, 8'h00, 8'h00}, '{16'h4002, 8'hA5, 8'hA5},
    '{16'h00BE, 8'h4A, 8'h2A}, '{16'h00BE, 8'h17, 8'h27}, '{16'h00BF, 8'hFF, 8'h00}};

  system_clock_and_power_control system_clock_and_power_control_inst (.ref_clk_i(ref_clk_i),
    .rst_i(rst_i), .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata),
    .sfr_rdata_o(rdata), .scan_mode_i(scan_mode_i), .gpio_i(gpio_i),
    .battery_insert_i(battery_insert_i), .sys_clk_o(sclk), .sys_tick_o(tick), .div_sel_o(div),
    .shutdown_o(shut), .wake_por_o(wake), .rtc_tick_clr_o(clr), .port_hold_o(hold),
    .osc_trim_code_o(trim));
  sfr_core_model sfr_core_model_inst (.clk_i(ref_clk_i), .rdata_i(rdata), .addr_o(addr),
    .wr_o(wr), .rd_o(rd), .wdata_o(wdata));

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  always @(negedge ref_clk_i) begin
    clr_cnt += int'(clr === 1'b1);
    wake_cnt += int'(wake === 1'b1);
  end
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic wr_r(input addr_t a, input byte_t d);
    sfr_core_model_inst.wr_reg(a, d);
  endtask
  task automatic rd_r(input addr_t a, input byte_t exp);
    byte_t v;
    sfr_core_model_inst.rd_reg(a, v);
    chk(v, exp, "read");
  endtask
  task automatic next_tick(output int k);
    k = 0;
    do begin
      @(negedge ref_clk_i);
      k++;
    end while (tick !== 1'b1 && k < 300);
  endtask
  task automatic do_reset(input logic batt);
    battery_insert_i = batt;
    rst_i = 1'b1;
    repeat (16) @(negedge ref_clk_i);
    rst_i = 1'b0;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    scan_mode_i = 1'b0;
    gpio_i = 9'h1FF;
    do_reset(1'b1);
    rd_r(16'h00BE, 8'h21);
    rd_r(16'h4002, 8'hFF);
    chk(8'(div), 8'h01, "div reset");
    chk(8'({shut, hold}), 8'h00, "reset levels");
    $display("test reset done");
    foreach (rows[i]) begin
      wr_r(rows[i].a, rows[i].d);
      rd_r(rows[i].a, rows[i].r);
    end
    chk(trim, 8'hA5, "trim out");
    $display("test rows done");
    for (int d = 0; d < 8; d++) begin
      wr_r(16'h00BE, byte_t'(d));
      repeat (300) @(negedge ref_clk_i);
      next_tick(n);
      next_tick(n);
      chk(byte_t'(n), byte_t'(1 << d), "tick period");
      hi = 0;
      repeat (1 << d) begin
        hi += int'(sclk === 1'b1);
        @(negedge ref_clk_i);
      end
      chk(8'(hi), 8'((1 << d) - ((1 << d) >> 1)), "clock high half");
      chk(8'(div), byte_t'(d), "div sel");
    end
    $display("test divider done");
    wr_r(16'h00BE, 8'h09);
    chk(8'(hold), 8'h01, "hold");
    rd_r(16'h00BE, 8'h29);
    clr_cnt = 0;
    wr_r(16'h00BE, 8'h11);
    repeat (4) @(negedge ref_clk_i);
    chk(8'(clr_cnt), 8'h01, "clear pulse");
    wr_r(16'h00BE, 8'h07);
    repeat (4) @(negedge ref_clk_i);
    chk(8'(clr_cnt), 8'h01, "clear by zero");
    $display("test bits done");
    scan_mode_i = 1'b1;
    repeat (6) @(negedge ref_clk_i);
    chk(8'(div), 8'h01, "scan div");
    wr_r(16'h00BE, 8'h87);
    repeat (4) @(negedge ref_clk_i);
    chk(8'(shut), 8'h00, "scan shutdown");
    scan_mode_i = 1'b0;
    repeat (6) @(negedge ref_clk_i);
    chk(8'(div), 8'h07, "div after scan");
    $display("test scan done");
    wake_cnt = 0;
    gpio_i = 9'h1F7;
    repeat (8) @(negedge ref_clk_i);
    chk(8'(wake_cnt), 8'h00, "wake while running");
    gpio_i = 9'h1FF;
    repeat (8) @(negedge ref_clk_i);
    wr_r(16'h00BE, 8'h81);
    repeat (2) @(negedge ref_clk_i);
    chk(8'(shut), 8'h01, "shutdown");
    gpio_i = 9'h0FF;
    repeat (10) @(negedge ref_clk_i);
    chk(8'(wake_cnt), 8'h01, "wake pulse");
    chk(8'(shut), 8'h00, "woken");
    wr_r(16'h00BE, 8'h81);
    rd_r(16'h00BE, 8'hA1);
    wr_r(16'h00BE, 8'h01);
    chk(8'(shut), 8'h00, "shutdown left by write");
    chk(8'(wake_cnt), 8'h01, "no wake by write");
    $display("test shutdown done");
    do_reset(1'b0);
    rd_r(16'h00BE, 8'h01);
    $display("test flag done");
    end_of_test();
  end
endmodule // system_clock_and_power_control_tb_top
`default_nettype wire
